// [include/branch_exec_consts.svh]
// Purpose: named constants for the branch and file-op execution block
// Assumes: 12-bit instruction words, 11-bit program counter, 8-bit data
// Notes: definitions only
`ifndef BRANCH_EXEC_CONSTS_SVH
`define BRANCH_EXEC_CONSTS_SVH

// ==========================================================
// widths and sizes
`define INSTR_W 12
`define PC_W 11
`define DATA_W 8
`define FADR_W 5
`define FILE_CNT 32
`define STK_DEPTH 2
`define WDT_W 8
`define PRESC_W 8

// ==========================================================
// status layout
`define STATUS_IDX 5'h03
`define PAGE_HI 6
`define PAGE_LO 5
`define FLAG_N_RST 1'b1
`define FLAG_N_SET 1'b1
`define ZERO_BYTE 8'h00

// ==========================================================
// instruction encodings
`define OPC_CALL 4'h9
`define OPC_ABSOLUTE_JUMP_OP 3'h5
`define WORD_WDTCLR 12'h004
`define OPC_FCLR 7'h03
`define OPC_FILE_COMPLEMENT_OP 6'h09
`define OPC_FILE_DECREMENT_OP 6'h03
`define OPC_DECREMENT_SKIP_ZERO_OP 6'h0b

`endif

// [include/branch_exec_pkg.sv]
// Purpose: types shared by the branch and file-op execution block
// Assumes: constants come from the consts header
// Notes: whole core state is one packed struct
`include "branch_exec_consts.svh"

package branch_exec_pkg;

    typedef enum {
        other_op,
        call_op,
        absolute_jump_op,
        watchdog_clear_op,
        file_clear_op,
        file_complement_op,
        file_decrement_op,
        decrement_skip_zero_op
    } exec_op_e;

    typedef struct packed {
        logic [`FADR_W-1:0] fadr;
        logic dest;
        logic [`PC_W-3:0] k9;
    } instr_fields_s;

    typedef struct packed {
        logic [`PC_W-1:0] pc;
        logic flush;
        logic [`STK_DEPTH-1:0][`PC_W-1:0] stack;
        logic [`DATA_W-1:0] w;
        logic [`FILE_CNT-1:0][`DATA_W-1:0] file;
        logic zero;
        logic timeout_flag_n;
        logic powerdown_flag_n;
        logic [`WDT_W-1:0] watchdog_counter;
        logic [`PRESC_W-1:0] presc;
    } core_state_s;

endpackage

// [hdl/branch_and_file_op_execution.sv]
// Purpose: executes call, jump, watchdog clear and file clear/complement/decrement ops
// Assumes: program memory returns the word at pmem_addr one cycle later
// Notes: every clock is one instruction cycle; other opcodes execute as no-ops
// Behaviour
// (RULE1) call pushes next instruction address first
// (RULE2) call loads 8-bit literal into pc[7:0]
// (RULE3) call takes page bits, clears pc[8]
// (RULE4) call takes two cycles, flags unchanged
// (RULE5) watchdog clear zeroes watchdog counter
// (RULE6) prescaler zeroed only when watchdog owns it
// (RULE7) watchdog clear sets timeout, powerdown flags
// (RULE8) file clear writes zero, sets zero flag
// (RULE9) complement inverts file, routes, updates zero
// (RULE10) destination 0 to w, 1 to file
// (RULE11) decrement subtracts one, routes, updates zero
// (RULE12) skip-decrement keeps flags, flushes on zero
// (RULE13) jump loads 9-bit literal plus page bits
// (RULE14) zero flag set exactly when result zero
`timescale 1ns/100ps

`include "branch_exec_consts.svh"

module branch_and_file_op_execution (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [`INSTR_W-1:0] instr,
    input wire logic instr_valid,
    input wire logic presc_to_wdt,
    input wire logic timeout_clear,
    input wire logic powerdown_clear,
    input wire logic [`FADR_W-1:0] peek_addr,
    output logic [`PC_W-1:0] pmem_addr,
    output logic exec_valid,
    output branch_exec_pkg::exec_op_e exec_op,
    output logic [`DATA_W-1:0] w_value,
    output logic [`DATA_W-1:0] peek_data,
    output logic zero_flag,
    output logic timeout_flag_n,
    output logic powerdown_flag_n,
    output logic [`WDT_W-1:0] watchdog_counter,
    output logic [`PRESC_W-1:0] presc_count,
    output logic [`PC_W-1:0] stack_top
);
    import branch_exec_pkg::*;

    // ==========================================================
    // decode
    function automatic exec_op_e decode_op(input logic [`INSTR_W-1:0] iw);
        exec_op_e op;
        op = other_op;
        if (iw[`INSTR_W-1 -: 4] == `OPC_CALL) begin
            op = call_op;
        end else if (iw[`INSTR_W-1 -: 3] == `OPC_ABSOLUTE_JUMP_OP) begin
            op = absolute_jump_op;
        end else if (iw == `WORD_WDTCLR) begin
            op = watchdog_clear_op;
        end else if (iw[`INSTR_W-1 -: 7] == `OPC_FCLR) begin
            op = file_clear_op;
        end else if (iw[`INSTR_W-1 -: 6] == `OPC_FILE_COMPLEMENT_OP) begin
            op = file_complement_op;
        end else if (iw[`INSTR_W-1 -: 6] == `OPC_FILE_DECREMENT_OP) begin
            op = file_decrement_op;
        end else if (iw[`INSTR_W-1 -: 6] == `OPC_DECREMENT_SKIP_ZERO_OP) begin
            op = decrement_skip_zero_op;
        end
        return op;
    endfunction

    core_state_s s_r;
    core_state_s s_nxt;
    instr_fields_s fld;
    exec_op_e op;
    logic ex;
    logic [1:0] page;
    logic [`DATA_W-1:0] fval;
    logic [`DATA_W-1:0] res;

    // a flushed slot still holds the fetched word but must run as a no-op
    assign ex = instr_valid && !s_r.flush;
    assign op = ex ? decode_op(instr) : other_op;
    // one driver for the whole field struct
    assign fld = {instr[`FADR_W-1:0], instr[`FADR_W], instr[`PC_W-3:0]};
    assign page = s_r.file[`STATUS_IDX][`PAGE_HI:`PAGE_LO];
    assign fval = s_r.file[fld.fadr];

    always_comb begin
        case (op)
            file_complement_op: res = ~fval; // [RULE9]
            file_decrement_op, decrement_skip_zero_op: res = fval - `DATA_W'(1); // [RULE11]
            default: res = `ZERO_BYTE;
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.flush = 1'b0;
        s_nxt.pc = s_r.pc + `PC_W'(1);
        s_nxt.presc = s_r.presc + `PRESC_W'(1);
        // watchdog ticks on prescaler wrap when it owns the prescaler
        if (!presc_to_wdt || &s_r.presc) begin
            s_nxt.watchdog_counter = s_r.watchdog_counter + `WDT_W'(1);
        end
        // external clears lose to the instruction setting the flags
        if (timeout_clear) begin
            s_nxt.timeout_flag_n = 1'b0;
        end
        if (powerdown_clear) begin
            s_nxt.powerdown_flag_n = 1'b0;
        end
        case (op)
            call_op: begin
                for (int i = `STK_DEPTH - 1; i > 0; i--) begin
                    s_nxt.stack[i] = s_r.stack[i-1];
                end
                s_nxt.stack[0] = s_r.pc; // [RULE1]
                s_nxt.pc = {page, 1'b0, instr[`DATA_W-1:0]}; // [RULE2] [RULE3]
                s_nxt.flush = 1'b1; // [RULE4]
            end
            absolute_jump_op: begin
                s_nxt.pc = {page, fld.k9}; // [RULE13]
                s_nxt.flush = 1'b1;
            end
            watchdog_clear_op: begin
                s_nxt.watchdog_counter = '0; // [RULE5]
                if (presc_to_wdt) begin
                    s_nxt.presc = '0; // [RULE6]
                end
                s_nxt.timeout_flag_n = `FLAG_N_SET; // [RULE7]
                s_nxt.powerdown_flag_n = `FLAG_N_SET;
            end
            file_clear_op: begin
                s_nxt.file[fld.fadr] = `ZERO_BYTE; // [RULE8]
                s_nxt.zero = 1'b1;
            end
            file_complement_op, file_decrement_op, decrement_skip_zero_op: begin
                if (fld.dest) begin
                    s_nxt.file[fld.fadr] = res; // [RULE10]
                end else begin
                    s_nxt.w = res;
                end
                if (op != decrement_skip_zero_op) begin
                    s_nxt.zero = (res == `ZERO_BYTE); // [RULE14]
                end else if (res == `ZERO_BYTE) begin
                    s_nxt.flush = 1'b1; // [RULE12]
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s_r <= '0;
            s_r.timeout_flag_n <= `FLAG_N_RST;
            s_r.powerdown_flag_n <= `FLAG_N_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign pmem_addr = s_r.pc;
    assign exec_valid = ex;
    assign exec_op = op;
    assign w_value = s_r.w;
    assign peek_data = s_r.file[peek_addr];
    assign zero_flag = s_r.zero;
    assign timeout_flag_n = s_r.timeout_flag_n;
    assign powerdown_flag_n = s_r.powerdown_flag_n;
    assign watchdog_counter = s_r.watchdog_counter;
    assign presc_count = s_r.presc;
    assign stack_top = s_r.stack[0];

    // ==========================================================
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    sequence call_seen;
        op == call_op;
    endsequence

    sequence slot_flushed;
        s_r.flush ##1 !s_r.flush;
    endsequence

    call_push_a: assert property (call_seen |=> stack_top == $past(pmem_addr)) // [RULE1]
        else $error("call did not push return address");
    call_low_a: assert property (call_seen |=> pmem_addr[7:0] == $past(instr[7:0])) // [RULE2]
        else $error("call literal not in pc low bits");
    call_page_a: assert property (call_seen |=> pmem_addr[10:8] == {$past(page), 1'b0}) // [RULE3]
        else $error("call upper pc bits wrong");
    call_cycles_a: assert property (call_seen |=> slot_flushed and $stable(zero_flag)) // [RULE4]
        else $error("call not two cycles or flags moved");
    wdt_zero_a: assert property (op == watchdog_clear_op |=> watchdog_counter == '0) // [RULE5]
        else $error("watchdog counter not cleared");
    presc_owner_a: assert property (op == watchdog_clear_op && !presc_to_wdt
        |=> presc_count == $past(presc_count) + `PRESC_W'(1)) // [RULE6]
        else $error("timer prescaler disturbed");
    presc_wdt_a: assert property (op == watchdog_clear_op && presc_to_wdt |=> presc_count == '0) // [RULE6]
        else $error("prescaler not cleared");
    flags_set_a: assert property (op == watchdog_clear_op
        |=> timeout_flag_n && powerdown_flag_n) // [RULE7]
        else $error("timeout or powerdown flag not set");
    fclr_zero_a: assert property (op == file_clear_op |=> zero_flag ##0
        s_r.file[$past(fld.fadr)] == `ZERO_BYTE) // [RULE8]
        else $error("file clear failed");
    comp_route_a: assert property (op == file_complement_op && !fld.dest
        |=> w_value == ~$past(fval) && zero_flag == (w_value == `ZERO_BYTE)) // [RULE9] [RULE10]
        else $error("complement to w wrong");
    dec_route_a: assert property (op == file_decrement_op && fld.dest
        |=> s_r.file[$past(fld.fadr)] == $past(fval) - `DATA_W'(1)) // [RULE11] [RULE10]
        else $error("decrement to file wrong");
    dec_zero_a: assert property (op == file_decrement_op
        |=> zero_flag == ($past(fval) == `DATA_W'(1))) // [RULE14]
        else $error("zero flag wrong after decrement");
    skip_zero_a: assert property (op == decrement_skip_zero_op
        |=> $stable(zero_flag) && s_r.flush == ($past(fval) == `DATA_W'(1))) // [RULE12]
        else $error("skip decrement flush or flag wrong");
    jump_target_a: assert property (op == absolute_jump_op
        |=> pmem_addr == {$past(page), $past(instr[8:0])} ##0 slot_flushed) // [RULE13]
        else $error("jump target wrong");

    // a flushed slot must never execute, whatever word sits on instr
    flush_idle_a: assert property (s_r.flush |-> !exec_valid) // [RULE12]
        else $error("flushed slot executed");

    // the older return address moves down one level on a push
    call_stack_a: assert property (call_seen |=> s_r.stack[1] == $past(stack_top)) // [RULE1]
        else $error("call stack not shifted");

    jump_flags_a: assert property (op == absolute_jump_op |=> $stable(zero_flag)) // [RULE13]
        else $error("jump moved the zero flag");

    comp_file_a: assert property (op == file_complement_op && fld.dest
        |=> s_r.file[$past(fld.fadr)] == ~$past(fval)) // [RULE9]
        else $error("complement to file wrong");

    dec_w_a: assert property (op == file_decrement_op && !fld.dest
        |=> w_value == $past(fval) - `DATA_W'(1)) // [RULE10]
        else $error("decrement to w wrong");

    skip_w_a: assert property (op == decrement_skip_zero_op && !fld.dest
        |=> w_value == $past(fval) - `DATA_W'(1)) // [RULE10]
        else $error("skip decrement to w wrong");

endmodule

// [dv/prog_mem_model.sv]
// Purpose: program memory model feeding prefetched words
// Assumes: word for addr shows one clock later
// Notes: drives all ones while reset holds
`timescale 1ns/100ps
module prog_mem_model (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [10:0] addr,
    output logic [11:0] word,
    output logic valid
);
    logic [11:0] mem [0:2047];
    initial begin
        foreach (mem[i]) mem[i] = 12'h000;
    end
    always_ff @(posedge clock) begin
        word <= rst_b ? mem[addr] : 12'hfff;
        valid <= rst_b;
    end
endmodule

// [dv/testbench.sv]
// Purpose: self-checking bench for branch and file-op execution
// Assumes: program preloaded into the memory model
// Notes: checks are taken at chosen fetch addresses
`timescale 1ns/100ps
module testbench;
    import branch_exec_pkg::*;
    logic clock, rst_b, iv, ptw, t_clr, p_clr, ev, zf, to_n, pd_n;
    logic [11:0] instr;
    logic [10:0] pc, stk;
    logic [7:0] w, pk, wdt, presc;
    logic [4:0] pa;
    exec_op_e eop;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    prog_mem_model u_pmem (.clock(clock), .rst_b(rst_b), .addr(pc), .word(instr), .valid(iv));
    branch_and_file_op_execution u_dut (
        .clock(clock), .rst_b(rst_b), .instr(instr), .instr_valid(iv),
        .presc_to_wdt(ptw), .timeout_clear(t_clr), .powerdown_clear(p_clr),
        .peek_addr(pa), .pmem_addr(pc), .exec_valid(ev), .exec_op(eop),
        .w_value(w), .peek_data(pk), .zero_flag(zf), .timeout_flag_n(to_n),
        .powerdown_flag_n(pd_n), .watchdog_counter(wdt), .presc_count(presc),
        .stack_top(stk));
    // ==========================================
    // shared tasks
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic peek(input logic [4:0] f, input logic [7:0] e);
        pa = f;
        #1;
        check(pk, e);
    endtask
    // bounded wait for a fetch address
    task automatic wait_pc(input logic [10:0] a);
        int n;
        n = 0;
        while (pc !== a && n < 100) begin
            @(posedge clock);
            #1;
            n++;
        end
        check(pc, a);
    endtask
    task automatic complete_run();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ==========================================
    // clock and hang guard
    initial begin
        clock = 0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 600) begin
            failures++;
            complete_run();
        end
    end
    // ==========================================
    // program and checks
    initial begin
        rst_b = 0;
        ptw = 1;
        t_clr = 1;
        p_clr = 1;
        pa = 5'h00;
        #1;
        u_pmem.mem['h000] = 12'h0e4;
        u_pmem.mem['h001] = 12'h245;
        u_pmem.mem['h002] = 12'h2e5;
        u_pmem.mem['h003] = 12'h004;
        u_pmem.mem['h004] = 12'ha10;
        u_pmem.mem['h005] = 12'h0e6;
        u_pmem.mem['h010] = 12'h920;
        u_pmem.mem['h011] = 12'h0e6;
        u_pmem.mem['h020] = 12'h0e8;
        u_pmem.mem['h021] = 12'h0e8;
        u_pmem.mem['h022] = 12'h268;
        u_pmem.mem['h023] = 12'h2c8;
        u_pmem.mem['h024] = 12'h0e9;
        u_pmem.mem['h025] = 12'h06a;
        u_pmem.mem['h026] = 12'h263;
        u_pmem.mem['h027] = 12'ha05;
        u_pmem.mem['h605] = 12'h940;
        u_pmem.mem['h606] = 12'h0e6;
        u_pmem.mem['h641] = 12'h004;
        repeat (20) @(posedge clock);
        #1;
        rst_b = 1;
        wait_pc(11'h003);
        check(w, 8'hff);
        check(zf, 1'b0);
        check(to_n, 1'b0);
        check(eop == decrement_skip_zero_op, 1'b1);
        peek(5'h05, 8'h00);
        t_clr = 0;
        p_clr = 0;
        wait_pc(11'h005);
        check(to_n, 1'b1);
        check(pd_n, 1'b1);
        check(wdt, 8'h00);
        check(presc, 8'h00);
        check(zf, 1'b0);
        peek(5'h05, 8'hff);
        peek(5'h04, 8'hff);
        ptw = 0;
        wait_pc(11'h010);
        check(ev, 1'b0);
        wait_pc(11'h020);
        check(stk, 11'h011);
        check(ev, 1'b0);
        wait_pc(11'h025);
        check(ev, 1'b0);
        check(w, 8'h00);
        check(zf, 1'b0);
        peek(5'h08, 8'h01);
        wait_pc(11'h027);
        check(zf, 1'b1);
        wait_pc(11'h605);
        check(zf, 1'b0);
        wait_pc(11'h640);
        check(stk, 11'h606);
        wait_pc(11'h643);
        check(wdt, 8'h00);
        check(presc == 8'h00, 1'b0);
        peek(5'h03, 8'hff);
        peek(5'h06, 8'h00);
        peek(5'h09, 8'h00);
        peek(5'h0a, 8'h00);
        complete_run();
    end
endmodule
